// ### cmps_pkg.sv
package cmps_pkg;
  // Clock rate and timer lengths
  localparam int unsigned CLK_HZ       = 50_000_000;
  localparam int unsigned CONFIRM_MS   = 125;
  localparam int unsigned CONFIRM_CYC  = (CLK_HZ / 1000) * CONFIRM_MS;
  // Feedback divider and analog levels in mV, kept for reference by the comparators, then the timer width
  localparam int unsigned FB_DIV_RATIO = 3;
  localparam int unsigned PEAK_MV      = 1000;
  localparam int unsigned SKIP_MV      = 750;
  localparam int unsigned SKIP_HYST_MV = 100;
  localparam int unsigned EXIT_MV      = 1250;
  localparam int unsigned TMR_W        = 24;
  // Control states
  typedef enum logic [1:0] {
    CMPS_RUN,
    CMPS_SKIP,
    CMPS_STANDBY,
    CMPS_FAULT
  } cmps_state_e;
endpackage

// ### cmps_timer_if.sv
`timescale 1ns/1ps
interface cmps_timer_if #(parameter int W = 24);
  logic run;
  logic expired;
  modport ctrl (output run, input expired);
  modport tmr  (input run, output expired);
endinterface

// ### cmps_confirm_timer.sv
`timescale 1ns/1ps
// Counts while run is high; clears at once when run drops, so it restarts from zero
module cmps_confirm_timer #(
  parameter int unsigned CYCLES = 24'd6250000,
  parameter int unsigned W      = 24
) (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Control
  cmps_timer_if.tmr t
);
  logic [W-1:0] cnt_q;

  // Elaboration check: the counter must reach the full length
  if (CYCLES < 1 || CYCLES >= (1 << W)) begin : g_len_chk
    $error("timer length does not fit");
  end

  // Count up, hold at terminal, clear when condition goes away
  always_ff @(posedge clk_i) begin
    if (rst_i || !t.run) begin
      cnt_q     <= '0;
      t.expired <= 1'b0;
    end else if (cnt_q != W'(CYCLES - 1)) begin
      cnt_q <= cnt_q + W'(1);
    end else begin
      t.expired <= 1'b1;
    end
  end
endmodule

// ### cmps_pwm_ctrl.sv
`timescale 1ns/1ps
// How it works
// - Oscillator sets drive, current crossing clears it
// - Sense compared with feedback divided by three
// - Peak sense clamped at 1.0 V
// - Feedback below 25% blanks drive pulses
// - Skip comparator has 100 mV hysteresis
// - Light load confirmed 125 ms opens PFC switch
// - Nominal load keeps PFC switch closed
// - Standby and overload disable PFC supply
// - Skipping under 1.25 V in standby keeps PFC off
// - Above 1.25 V leaves skip, resumes switching
// - Leaving standby closes PFC switch immediately
// - Error flag held 125 ms stops drive
module cmps_pwm_ctrl #(
  parameter int unsigned CONFIRM_CYC = cmps_pkg::CONFIRM_CYC
) (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Oscillator and comparators
  input  wire logic osc_tick_i,       // One-cycle pulse at each oscillator clock
  input  wire logic cs_over_fb_i,     // Sense above feedback/3
  input  wire logic cs_over_peak_i,   // Sense above 1.0 V clamp; also the error flag
  input  wire logic fb_below_skip_i,  // Skip comparator, hysteresis in the analog path
  input  wire logic fb_above_exit_i,  // Feedback above 1.25 V
  // Outputs
  output logic      gate_drive_o,
  output logic      pfc_supply_switch_o,  // High closes switch, feeding pfc_supply_output
  output logic      skip_active_o,
  output logic      fault_stop_o
);
  // Load state and latched flags
  cmps_pkg::cmps_state_e state_q;
  logic                  err_q;
  logic                  skip_q;
  // Decoded state
  logic                  in_run;
  logic                  in_skip;
  logic                  in_standby;
  // Drive latch terms and exit request
  logic                  drive_clr;
  logic                  drive_set;
  logic                  exit_req;
  // Timer run conditions
  logic                  light_run;
  logic                  fault_run;
  // Timer handshakes
  cmps_timer_if #(.W(cmps_pkg::TMR_W)) lt_if ();
  cmps_timer_if #(.W(cmps_pkg::TMR_W)) ft_if ();

  // Elaboration check: the timer must hold the full confirmation count
  if (CONFIRM_CYC < 1 || CONFIRM_CYC >= (1 << cmps_pkg::TMR_W)) begin : g_cyc_chk
    $error("confirmation length does not fit the timer");
  end

  // State decode, shared by the light-load timer and the PFC switch
  function automatic logic st_is(input cmps_pkg::cmps_state_e s,
                                 input cmps_pkg::cmps_state_e want);
    return s == want;
  endfunction

  // Decoded load state
  assign in_run     = st_is(state_q, cmps_pkg::CMPS_RUN);
  assign in_skip    = st_is(state_q, cmps_pkg::CMPS_SKIP);
  assign in_standby = st_is(state_q, cmps_pkg::CMPS_STANDBY);

  // Leaving skip or standby needs feedback above 1.25 V; the skip level alone
  // is not enough, which keeps burst ripple from toggling the PFC supply
  assign exit_req = fb_above_exit_i;

  // Clear terms: feedback/3 crossing, 1.0 V clamp, confirmed fault
  // They win over the oscillator set when both land in one cycle
  assign drive_clr = err_q || cs_over_fb_i || cs_over_peak_i;
  // Set term: oscillator clock, blanked while skipping or below skip level
  assign drive_set = osc_tick_i && !skip_q && !fb_below_skip_i;

  // Light-load timer runs only while skipping with feedback below the skip level;
  // any rise above it drops run and the timer starts again from zero
  assign light_run = skip_q && fb_below_skip_i && in_skip;
  // Fault timer runs while the error flag is high; a short flag never stops drive
  assign fault_run = cs_over_peak_i && !err_q;
  assign lt_if.run = light_run;
  assign ft_if.run = fault_run;

  // Light-load confirmation timer
  cmps_confirm_timer #(.CYCLES(CONFIRM_CYC), .W(cmps_pkg::TMR_W)) u_light (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .t     (lt_if.tmr)
  );

  // Overload confirmation timer
  cmps_confirm_timer #(.CYCLES(CONFIRM_CYC), .W(cmps_pkg::TMR_W)) u_fault (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .t     (ft_if.tmr)
  );

  // Skip flag is set by the hysteretic comparator; only the exit level clears it
  // The hysteresis sits in the analog path, so no filtering is done here
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      skip_q <= 1'b0;
    end else if (exit_req) begin
      skip_q <= 1'b0;
    end else if (fb_below_skip_i) begin
      skip_q <= 1'b1;
    end
  end

  // Fault latch: stays set until supply restart
  // The flag must still be high at expiry, or nothing is latched
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      err_q <= 1'b0;
    end else if (ft_if.expired && cs_over_peak_i) begin
      err_q <= 1'b1;
    end
  end

  // Load state machine
  // Run to skip on the skip flag, skip to standby on confirmed light load,
  // standby back to run on the exit level, any state to fault on overload
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= cmps_pkg::CMPS_RUN;
    end else begin
      case (state_q)
        cmps_pkg::CMPS_RUN: begin
          if (err_q) begin
            state_q <= cmps_pkg::CMPS_FAULT;
          end else if (skip_q) begin
            state_q <= cmps_pkg::CMPS_SKIP;
          end
        end
        cmps_pkg::CMPS_SKIP: begin
          if (err_q) begin
            state_q <= cmps_pkg::CMPS_FAULT;
          end else if (!skip_q) begin
            state_q <= cmps_pkg::CMPS_RUN;
          end else if (lt_if.expired) begin
            state_q <= cmps_pkg::CMPS_STANDBY;
          end
        end
        cmps_pkg::CMPS_STANDBY: begin
          if (err_q) begin
            state_q <= cmps_pkg::CMPS_FAULT;
          end else if (exit_req) begin
            state_q <= cmps_pkg::CMPS_RUN;
          end
        end
        cmps_pkg::CMPS_FAULT: begin
          state_q <= cmps_pkg::CMPS_FAULT;
        end
        default: begin
          state_q <= cmps_pkg::CMPS_RUN;
        end
      endcase
    end
  end

  // Drive latch: set by oscillator, reset by current crossing
  // Held off after a clear until the next oscillator clock
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gate_drive_o <= 1'b0;
    end else if (drive_clr) begin
      gate_drive_o <= 1'b0;
    end else if (drive_set) begin
      gate_drive_o <= 1'b1;
    end
  end

  // PFC supply switch: closed in run and skip, open in standby or fault
  // Skip alone keeps it closed: only a confirmed light load or a fault opens it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pfc_supply_switch_o <= 1'b1;
    end else if (err_q) begin
      pfc_supply_switch_o <= 1'b0;
    end else if (in_standby && exit_req) begin
      pfc_supply_switch_o <= 1'b1;
    end else if (in_standby) begin
      pfc_supply_switch_o <= 1'b0;
    end else if (in_run) begin
      pfc_supply_switch_o <= 1'b1;
    end
  end

  // Skip status, one cycle behind the internal flag
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      skip_active_o <= 1'b0;
    end else begin
      skip_active_o <= skip_q;
    end
  end

  // Fault status, held until reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fault_stop_o <= 1'b0;
    end else begin
      fault_stop_o <= err_q;
    end
  end
endmodule

// ### cmps_sense_model.sv
`timescale 1ns/1ps
// Primary current ramp: sense crosses feedback/3 a few cycles into each pulse
module cmps_sense_model (
  input  wire logic clk_i,
  input  wire logic gate_i,
  output logic      cs_over_fb_o
);
  logic [3:0] on_q;
  // Current builds while the switch is on and collapses when it opens
  always_ff @(posedge clk_i) begin
    on_q <= gate_i ? on_q + 4'h1 : 4'h0;
  end
  assign cs_over_fb_o = gate_i && (on_q >= 4'h3);
endmodule

// ### cmps_pwm_ctrl_chk.sv
`timescale 1ns/1ps
// Port checks on drive, skip and PFC supply control
module cmps_pwm_ctrl_chk (
  input wire logic clk_i, rst_i, osc_tick_i, cs_over_fb_i, cs_over_peak_i, fb_below_skip_i,
  input wire logic fb_above_exit_i, gate_drive_o, pfc_supply_switch_o, skip_active_o, fault_stop_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  AST_GATE_SET: assert property (osc_tick_i && !cs_over_fb_i && !cs_over_peak_i &&
    !fault_stop_o && !skip_active_o && !fb_below_skip_i && !$past(fb_below_skip_i)
    |=> gate_drive_o) else $error("gate not set");
  AST_CLR: assert property ((cs_over_fb_i || cs_over_peak_i) |=> !gate_drive_o)
    else $error("gate not cleared");
  AST_SKIP_BLANK: assert property (skip_active_o && !fb_above_exit_i
    && !$past(fb_above_exit_i) |=> !$rose(gate_drive_o)) else $error("pulse in skip");
  AST_STANDBY_WAIT: assert property ($fell(pfc_supply_switch_o) && !cs_over_peak_i
    |-> $past(fb_below_skip_i, 10)) else $error("standby too early");
  AST_PFC_FALL: assert property ($fell(pfc_supply_switch_o)
    |-> ##[0:2] (skip_active_o || fault_stop_o)) else $error("pfc off at load");
  AST_EXIT: assert property (!pfc_supply_switch_o && fb_above_exit_i && !fault_stop_o
    && !cs_over_peak_i |=> pfc_supply_switch_o) else $error("pfc not restored");
  AST_SKIP_LEAVE: assert property ($fell(skip_active_o)
    |-> $past(fb_above_exit_i, 2) || fault_stop_o) else $error("skip left early");
  AST_FAULT_WAIT: assert property ($rose(fault_stop_o) |-> $past(cs_over_peak_i, 10))
    else $error("fault too early");
  // Main scenarios
  cover property ($rose(gate_drive_o));
  cover property ($fell(pfc_supply_switch_o));
  cover property ($rose(fault_stop_o));
endmodule
bind cmps_pwm_ctrl cmps_pwm_ctrl_chk chk_u (.clk_i(clk_i), .rst_i(rst_i),
  .osc_tick_i(osc_tick_i), .cs_over_fb_i(cs_over_fb_i), .cs_over_peak_i(cs_over_peak_i),
  .fb_below_skip_i(fb_below_skip_i), .fb_above_exit_i(fb_above_exit_i), .gate_drive_o(gate_drive_o),
  .pfc_supply_switch_o(pfc_supply_switch_o), .skip_active_o(skip_active_o),
  .fault_stop_o(fault_stop_o));

// ### current_mode_pwm_skip_manager_tb.sv
`timescale 1ns/1ps
module current_mode_pwm_skip_manager_tb;
  logic clk_i = 1'b0, rst_i = 1'b1, tk = 1'b0, pk = 1'b0, lo = 1'b0, hi = 1'b0;
  logic cf, g, p, s, f;
  int bad_count = 0, n_compared = 0, cyc = 0;
  // Clock, sense model and device
  always #10 clk_i = ~clk_i;
  cmps_sense_model sns_u (.clk_i(clk_i), .gate_i(g), .cs_over_fb_o(cf));
  cmps_pwm_ctrl #(.CONFIRM_CYC(20)) dut_u (.clk_i(clk_i), .rst_i(rst_i), .osc_tick_i(tk),
    .cs_over_fb_i(cf), .cs_over_peak_i(pk), .fb_below_skip_i(lo), .fb_above_exit_i(hi),
    .gate_drive_o(g), .pfc_supply_switch_o(p), .skip_active_o(s), .fault_stop_o(f));
  task automatic chk(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Stimulus moves on rising edges, outputs are looked at on falling edges
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic look;
    @(negedge clk_i);
  endtask
  task automatic complete_run;
    $display("compared=%0d mismatches=%0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Hang guard: the scenarios need about 94 cycles
  always @(posedge clk_i) begin
    cyc++;
    if (cyc > 400) begin
      bad_count++;
      complete_run();
    end
  end
  // One pulse, ended by the sense ramp four cycles in
  task automatic run_pulse;
    tick(1);
    tk <= 1'b1;
    tick(1);
    tk <= 1'b0;
    look();
    chk(g, 1'b1);
    chk(p, 1'b1);
    tick(3);
    look();
    chk(g, 1'b1);
    tick(1);
    look();
    chk(g, 1'b0);
  endtask
  // Pulse cut short by the 1.0 V clamp
  task automatic clamp_pulse;
    tick(1);
    tk <= 1'b1;
    tick(1);
    tk <= 1'b0;
    pk <= 1'b1;
    look();
    chk(g, 1'b1);
    tick(1);
    pk <= 1'b0;
    look();
    chk(g, 1'b0);
  endtask
  // Light load with one recovery, then confirmed standby and ripple
  task automatic light_load;
    tick(1);
    lo <= 1'b1;
    tick(10);
    lo <= 1'b0;
    tick(1);
    lo <= 1'b1;
    tick(1);
    tk <= 1'b1;
    tick(1);
    tk <= 1'b0;
    look();
    chk(g, 1'b0);
    chk(s, 1'b1);
    tick(13);
    look();
    chk(p, 1'b1);
    tick(6);
    look();
    chk(p, 1'b1);
    tick(1);
    look();
    chk(p, 1'b0);
    tick(1);
    lo <= 1'b0;
    tick(2);
    lo <= 1'b1;
    look();
    chk(p, 1'b0);
    chk(s, 1'b1);
  endtask
  // Feedback above the exit level ends standby and skip
  task automatic leave_standby;
    tick(1);
    hi <= 1'b1;
    lo <= 1'b0;
    tick(1);
    hi <= 1'b0;
    look();
    chk(p, 1'b1);
    tick(1);
    look();
    chk(s, 1'b0);
    tick(1);
    tk <= 1'b1;
    tick(1);
    tk <= 1'b0;
    look();
    chk(g, 1'b1);
  endtask
  // Short error flag is ignored, a long one stops the drive
  task automatic overload;
    tick(1);
    pk <= 1'b1;
    tick(10);
    pk <= 1'b0;
    tick(2);
    look();
    chk(f, 1'b0);
    chk(p, 1'b1);
    tick(1);
    pk <= 1'b1;
    tick(21);
    look();
    chk(f, 1'b0);
    tick(1);
    look();
    chk(f, 1'b1);
    chk(g, 1'b0);
    chk(p, 1'b0);
  endtask
  // Reset in mid-run clears the fault and restores switching
  task automatic restart;
    tick(1);
    rst_i <= 1'b1;
    pk    <= 1'b0;
    tick(2);
    rst_i <= 1'b0;
    look();
    chk(f, 1'b0);
    chk(p, 1'b1);
    chk(s, 1'b0);
    tick(1);
    tk <= 1'b1;
    tick(1);
    tk <= 1'b0;
    look();
    chk(g, 1'b1);
  endtask
  initial begin
    tick(2);
    rst_i <= 1'b0;
    run_pulse();
    clamp_pulse();
    light_load();
    leave_standby();
    overload();
    restart();
    complete_run();
  end
endmodule
